// file: rtl/hss_ctrl.sv
// Top: link slave, switch control registers, supply shutdown and aux pin modes
`timescale 1ns/100ps
module hss_ctrl #(
   parameter int TICK_CYC = hss_pkg::TICK_CYCLES // Timebase tick length in clocks
) (
   input  wire logic       clock_i,          // System clock 20 MHz
   input  wire logic       rst_i,            // Power-on reset, synchronous
   input  wire logic       soft_reset_i,     // Soft reset pin
   input  wire logic       sclk_i,           // Link clock from host
   input  wire logic       csn_n_i,          // Link select, active low
   input  wire logic       mosi_i,           // Link data in
   output logic            miso_o,           // Link data out
   output logic            miso_oe_n_o,      // Link data out enable, active low
   input  wire logic       restart_clear_i,  // Restart mode clears switches
   input  wire logic       cyclic_sense_i,   // Cyclic sensing in use
   input  wire logic       supply_ov_i,      // Switch supply overvoltage
   input  wire logic       supply_uv_i,      // Switch supply undervoltage
   input  wire logic [3:0] overcurrent_i,    // Per-switch overcurrent
   input  wire logic [3:0] overtemp_i,       // Per-switch overtemperature
   input  wire logic       fail_active_i,    // Device fail state
   input  wire logic [1:0] aux_pin_i,        // Aux pin levels
   input  wire logic       first_timer_i,    // First cyclic timer output
   input  wire logic [7:0] pulse_one_duty_i, // First pulse generator duty
   input  wire logic [7:0] pulse_two_duty_i, // Second pulse generator duty
   input  wire logic       pulse_one_freq_i, // First pulse generator rate
   input  wire logic       pulse_two_freq_i, // Second pulse generator rate
   output logic [3:0]      switch_on_o,      // Switch drive
   output logic [1:0]      aux_hs_on_o,      // Aux pin high-side drive
   output logic [1:0]      aux_ls_on_o,      // Aux pin low-side drive
   output logic [1:0]      aux_fail_o,       // Aux pin fail output
   output logic [1:0]      aux_wake_en_o,    // Aux pin wake input enabled
   output logic [1:0]      aux_wake_o,       // Filtered wake level
   output logic            second_timer_o    // Second timer output
);
   import hss_pkg::*;

   localparam int NSYNC = 17;

   // ==========================================================
   // Link domain
   logic [1:0]  lrst_q;
   logic [3:0]  bit_q;
   logic [15:0] shift_q;
   hss_pkg::frame_t frame_q;
   logic        frame_tgl_q;

   always_ff @(posedge sclk_i) begin
      lrst_q <= {lrst_q[0], rst_i};
   end

   always_ff @(posedge sclk_i) begin
      if (lrst_q[1]) begin
         bit_q       <= 4'h0;
         shift_q     <= 16'h0000;
         frame_tgl_q <= 1'b0;
      end else if (!csn_n_i) begin
         bit_q   <= bit_q + 4'h1;
         shift_q <= {mosi_i, shift_q[15:1]};
         if (bit_q == 4'hf) begin
            frame_tgl_q <= ~frame_tgl_q;
         end
      end
   end

   // Held word stays still until the next frame completes
   always_ff @(posedge sclk_i) begin
      if (lrst_q[1]) begin
         frame_q <= '0;
      end else if (!csn_n_i && bit_q == 4'hf) begin
         frame_q <= {mosi_i, shift_q[15:1]};
      end
   end

   // Read byte is held stable between frames, so it may be sampled here
   logic [7:0] rdata_q;
   logic [2:0] rd_idx;
   assign rd_idx = 3'(bit_q - 4'h8);

   always_ff @(negedge sclk_i) begin
      if (lrst_q[1]) begin
         miso_o      <= 1'b0;
         miso_oe_n_o <= 1'b1;
      end else begin
         miso_oe_n_o <= csn_n_i;
         miso_o      <= bit_q[3] ? rdata_q[rd_idx] : 1'b0;
      end
   end

   // ==========================================================
   // Synchronisers into the system domain
   logic [NSYNC-1:0] sync_m_q;
   logic [NSYNC-1:0] sync_q;
   logic [NSYNC-1:0] pins;
   logic             tgl_p_q;
   logic             frame_evt;

   assign pins = {frame_tgl_q, soft_reset_i, restart_clear_i, cyclic_sense_i, supply_ov_i,
                  supply_uv_i, overcurrent_i, overtemp_i, fail_active_i, aux_pin_i};

   always_ff @(posedge clock_i) begin
      sync_m_q <= pins;
      sync_q   <= sync_m_q;
      tgl_p_q  <= sync_q[16];
   end

   logic       soft_s, restart_s, cyclic_s, ov_s, uv_s, fail_s;
   logic [3:0] fault_s;
   logic [1:0] aux_s;
   assign soft_s    = sync_q[15];
   assign restart_s = sync_q[14];
   assign cyclic_s  = sync_q[13];
   assign ov_s      = sync_q[12];
   assign uv_s      = sync_q[11];
   assign fault_s   = sync_q[10:7] | sync_q[6:3];
   assign fail_s    = sync_q[2];
   assign aux_s     = sync_q[1:0];
   assign frame_evt = sync_q[16] ^ tgl_p_q;

   // ==========================================================
   // Register file
   logic       clr;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] tim_q, sd_q, src_a_q, src_b_q, aux_q;
   logic       sd_now;
   logic       sd_clear;

   assign clr      = rst_i || soft_s;
   assign wr       = frame_evt && frame_q.wr;
   assign wdata    = frame_q.data;
   assign sd_now   = (ov_s && !sd_q[OV_DIS_BIT]) || (uv_s && !sd_q[UV_DIS_BIT]);
   assign sd_clear = sd_now && !sd_q[RECOVER_BIT];

   always_ff @(posedge clock_i) begin
      if (clr) begin
         tim_q <= RESET_VALUE;
      end else if (restart_s && cyclic_s) begin
         tim_q <= RESET_VALUE;
      end else if (wr && frame_q.addr == ADDR_SECOND_CYCLIC_TIMER) begin
         tim_q <= wdata & MASK_SECOND_CYCLIC_TIMER;
      end
   end

   always_ff @(posedge clock_i) begin
      if (clr) begin
         sd_q  <= RESET_VALUE;
         aux_q <= RESET_VALUE;
      end else if (wr) begin
         if (frame_q.addr == ADDR_SHUTDOWN) begin
            sd_q <= wdata & MASK_SHUTDOWN;
         end
         if (frame_q.addr == ADDR_AUX) begin
            aux_q <= wdata & MASK_AUX;
         end
      end
   end

   // Source fields: hardware clears override a same-cycle write
   logic [3:0][2:0] src_now;
   logic [3:0][2:0] src_nxt;
   logic [3:0]      src_wr;
   assign src_now = {src_b_q[HI_FIELD +: 3], src_b_q[LO_FIELD +: 3],
                     src_a_q[HI_FIELD +: 3], src_a_q[LO_FIELD +: 3]};

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         src_wr[i]  = wr && (frame_q.addr == ((i < 2) ? ADDR_SRC_A : ADDR_SRC_B));
         src_nxt[i] = src_wr[i] ? wdata[((i % 2) * HI_FIELD) +: 3] : src_now[i];
         if (fault_s[i] || sd_clear || restart_s) begin
            src_nxt[i] = SRC_OFF;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (clr) begin
         src_a_q <= RESET_VALUE;
         src_b_q <= RESET_VALUE;
      end else begin
         src_a_q <= {1'b0, src_nxt[1], 1'b0, src_nxt[0]};
         src_b_q <= {1'b0, src_nxt[3], 1'b0, src_nxt[2]};
      end
   end

   // Readback of the addressed register; unmapped reads as zero
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (frame_evt) begin
         unique case (frame_q.addr)
            ADDR_SECOND_CYCLIC_TIMER:   rdata_q <= tim_q;
            ADDR_SHUTDOWN: rdata_q <= sd_q;
            ADDR_SRC_A:    rdata_q <= src_a_q;
            ADDR_SRC_B:    rdata_q <= src_b_q;
            ADDR_AUX:      rdata_q <= aux_q;
            default:       rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Timebase, second timer, pulse generators
   logic [15:0] tick_q;
   logic        tick;
   logic        tim_restart;
   logic        t2_out, p1_out, p2_out;

   assign tick        = (tick_q == 16'(TICK_CYC - 1));
   assign tim_restart = wr && frame_q.addr == ADDR_SECOND_CYCLIC_TIMER;

   always_ff @(posedge clock_i) begin
      if (rst_i || tick) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   cyclic_timer u_second_timer (
      .clock_i    (clock_i),
      .rst_i      (clr),
      .tick_i     (tick),
      .restart_i  (tim_restart),
      .on_code_i  (tim_q[6:4]),
      .per_code_i (tim_q[2:0]),
      .out_o      (t2_out)
   );

   pulse_gen u_pulse_one (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .duty_i  (pulse_one_duty_i),
      .freq_i  (pulse_one_freq_i),
      .out_o   (p1_out)
   );

   pulse_gen u_pulse_two (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .duty_i  (pulse_two_duty_i),
      .freq_i  (pulse_two_freq_i),
      .out_o   (p2_out)
   );

   // ==========================================================
   // Switch drive; with recovery on, sources survive and drive resumes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         switch_on_o    <= 4'h0;
         second_timer_o <= 1'b0;
      end else begin
         second_timer_o <= t2_out;
         for (int i = 0; i < 4; i++) begin
            unique case (src_now[i])
               SRC_ON:     switch_on_o[i] <= !sd_now;
               SRC_FIRST_CYCLIC_TIMER: switch_on_o[i] <= !sd_now && first_timer_i;
               SRC_SECOND_CYCLIC_TIMER: switch_on_o[i] <= !sd_now && t2_out;
               SRC_PULSE1: switch_on_o[i] <= !sd_now && p1_out;
               SRC_PULSE2: switch_on_o[i] <= !sd_now && p2_out;
               default:    switch_on_o[i] <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // Third fail output duty pattern
   logic [15:0] fail_cnt_q;
   logic [15:0] fail_on;
   assign fail_on = 16'(FAIL_TICKS * FAIL_PERMILLE[aux_q[DUTY_LSB +: 2]] / 1000);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fail_cnt_q <= 16'h0000;
      end else if (tick) begin
         fail_cnt_q <= (fail_cnt_q == 16'(FAIL_TICKS - 1)) ? 16'h0000 : fail_cnt_q + 16'h0001;
      end
   end

   // ==========================================================
   // Aux pins: mode decode and static wake filter
   logic [1:0][2:0] pin_mode;
   logic [1:0][8:0] filt_q;
   logic [1:0]      fail_lvl;
   assign pin_mode = {aux_q[PIN_TWO_LSB +: 3], aux_q[2:0]};
   assign fail_lvl = {fail_s && (fail_cnt_q < fail_on), fail_s};

   // Wake level changes only after the pin holds steady for the full filter time
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         filt_q     <= '0;
         aux_wake_o <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (aux_s[i] == aux_wake_o[i] || pin_mode[i] != PIN_WAKE) begin
               filt_q[i] <= 9'h000;
            end else if (filt_q[i] == 9'(WAKE_CYCLES - 1)) begin
               filt_q[i]     <= 9'h000;
               aux_wake_o[i] <= aux_s[i];
            end else begin
               filt_q[i] <= filt_q[i] + 9'h001;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         aux_hs_on_o   <= 2'b00;
         aux_ls_on_o   <= 2'b00;
         aux_fail_o    <= 2'b00;
         aux_wake_en_o <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            aux_hs_on_o[i]   <= pin_mode[i] == PIN_HI_ON;
            aux_ls_on_o[i]   <= pin_mode[i] == PIN_LOW_ON;
            aux_fail_o[i]    <= !pin_mode[i][2] && fail_lvl[i];
            aux_wake_en_o[i] <= pin_mode[i] == PIN_WAKE;
         end
      end
   end

endmodule : hss_ctrl

// file: rtl/hss_pkg.sv
// Package: register map, field layout, timing constants and carriers for the switch control
// How it works
// - Second timer on-time code 1..5 picks 0.1 to 20 ms; code 0 holds output low.
// - On-time code 110 stops the timer and holds controlled switches high.
// - Period code 0..6 picks 10 ms to 2 s; code 7 is reserved and idle.
// - Timer starts by itself once a running on-time code is written.
// - Restart clearing with cyclic sensing also clears timer period and on-time.
// - Shutdown bit 6 at 0 turns all switches off on supply overvoltage.
// - Shutdown bit 5 at 0 turns all switches off on supply undervoltage.
// - Bit 4 at 1 restores switches after the supply fault; 0 keeps them off.
// - Three-bit source per switch: off, on, timers, pulse generators; 110/111 reserved.
// - Overcurrent or overtemperature clears that switch's source field to off.
// - Duty field 7:6 sets third fail output duty: 20, 10, 5, 2.5 percent.
// - Aux pin modes: 0-3 fail output, 4 off, 6 low-side on, 7 high-side on.
// - Aux pin mode 101 enables a wake input with 16 us static filter.
// - Reserved bits read zero and ignore writes.
// - Power-on or soft reset loads zero into all these registers.
// - Pulse duty value over 255 is the on fraction; 0 off, 255 on.
// - Pulse frequency bit selects 200 Hz at 0 and 400 Hz at 1.
package hss_pkg;

   // ==========================================================
   // Register offsets (7-bit link address)
   localparam logic [6:0] ADDR_SECOND_CYCLIC_TIMER   = 7'h0d;
   localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
   localparam logic [6:0] ADDR_SRC_A    = 7'h14;
   localparam logic [6:0] ADDR_SRC_B    = 7'h15;
   localparam logic [6:0] ADDR_AUX      = 7'h17;
   localparam logic [7:0] RESET_VALUE   = 8'h00;

   // ==========================================================
   // Field positions and writable masks
   localparam int         LO_FIELD      = 0;
   localparam int         HI_FIELD      = 4;
   localparam int         OV_DIS_BIT    = 6;
   localparam int         UV_DIS_BIT    = 5;
   localparam int         RECOVER_BIT   = 4;
   localparam int         PIN_TWO_LSB   = 3;
   localparam int         DUTY_LSB      = 6;
   localparam logic [7:0] MASK_SECOND_CYCLIC_TIMER   = 8'h77;
   localparam logic [7:0] MASK_SHUTDOWN = 8'h70;
   localparam logic [7:0] MASK_SRC      = 8'h77;
   localparam logic [7:0] MASK_AUX      = 8'hff;

   // ==========================================================
   // Codes
   localparam logic [2:0] SRC_OFF    = 3'h0;
   localparam logic [2:0] SRC_ON     = 3'h1;
   localparam logic [2:0] SRC_FIRST_CYCLIC_TIMER = 3'h2;
   localparam logic [2:0] SRC_SECOND_CYCLIC_TIMER = 3'h3;
   localparam logic [2:0] SRC_PULSE1 = 3'h4;
   localparam logic [2:0] SRC_PULSE2 = 3'h5;
   localparam logic [2:0] ON_LOW     = 3'h0;
   localparam logic [2:0] ON_HIGH    = 3'h6;
   localparam logic [2:0] CODE_RSVD  = 3'h7;
   localparam logic [2:0] PIN_OFF    = 3'h4;
   localparam logic [2:0] PIN_WAKE   = 3'h5;
   localparam logic [2:0] PIN_LOW_ON = 3'h6;
   localparam logic [2:0] PIN_HI_ON  = 3'h7;

   // ==========================================================
   // Timing: clock, timer tick, filters, pulse generators
   localparam int CLK_KHZ        = 20000;
   localparam int TICK_US        = 100;
   localparam int TICK_CYCLES    = CLK_KHZ * TICK_US / 1000;
   localparam int WAKE_FILTER_US = 16;
   localparam int WAKE_CYCLES    = (CLK_KHZ * WAKE_FILTER_US + 999) / 1000;
   localparam int PULSE_STEPS    = 255;
   localparam int PULSE_LO_HZ    = 200;
   localparam int PULSE_HI_HZ    = 400;
   localparam int PULSE_LO_STEP  = CLK_KHZ * 1000 / (PULSE_LO_HZ * PULSE_STEPS);
   localparam int PULSE_HI_STEP  = CLK_KHZ * 1000 / (PULSE_HI_HZ * PULSE_STEPS);
   localparam int FAIL_PERIOD_MS = 200;
   localparam int FAIL_TICKS     = FAIL_PERIOD_MS * 1000 / TICK_US;
   // On-times in microseconds for codes 1..5, periods in milliseconds for codes 0..6
   localparam int ON_US  [8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
   localparam int PER_MS [8] = '{10, 20, 50, 100, 200, 1000, 2000, 0};
   // Fail duty in tenths of a percent for codes 0..3
   localparam int FAIL_PERMILLE [4] = '{200, 100, 50, 25};

   // ==========================================================
   // Link frame carrier: LSB first, address, write flag, then data
   typedef struct packed {
      logic [7:0] data;
      logic       wr;
      logic [6:0] addr;
   } frame_t;

endpackage : hss_pkg

// file: rtl/cyclic_timer.sv
// Cyclic timer: on-time pulse at the start of every period
`timescale 1ns/100ps
module cyclic_timer (
   input  wire logic       clock_i,   // System clock
   input  wire logic       rst_i,     // Synchronous reset
   input  wire logic       tick_i,    // Timebase tick
   input  wire logic       restart_i, // Restart the period
   input  wire logic [2:0] on_code_i, // On-time code
   input  wire logic [2:0] per_code_i,// Period code
   output logic            out_o      // Timer output
);
   import hss_pkg::*;

   logic [15:0] cnt_q;
   logic [15:0] on_ticks;
   logic [15:0] per_ticks;
   logic        run;

   always_comb begin
      on_ticks  = 16'(ON_US[on_code_i] / TICK_US);
      per_ticks = 16'(PER_MS[per_code_i] * 1000 / TICK_US);
      run = (on_code_i != ON_LOW) && (on_code_i != ON_HIGH)
            && (on_code_i != CODE_RSVD) && (per_code_i != CODE_RSVD);
   end

   // New settings restart the period so the first pulse follows the write
   always_ff @(posedge clock_i) begin
      if (rst_i || restart_i || !run) begin
         cnt_q <= 16'h0000;
      end else if (tick_i) begin
         cnt_q <= (cnt_q + 16'h0001 >= per_ticks) ? 16'h0000 : cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         out_o <= 1'b0;
      end else if (on_code_i == ON_HIGH) begin
         out_o <= 1'b1;
      end else begin
         out_o <= run && (cnt_q < on_ticks);
      end
   end

endmodule : cyclic_timer

// file: rtl/pulse_gen.sv
// Pulse generator: 8-bit duty over 255 steps, 200 or 400 Hz
`timescale 1ns/100ps
module pulse_gen (
   input  wire logic       clock_i, // System clock
   input  wire logic       rst_i,   // Synchronous reset
   input  wire logic [7:0] duty_i,  // Duty value
   input  wire logic       freq_i,  // 0 low rate, 1 high rate
   output logic            out_o    // Pulse output
);
   import hss_pkg::*;

   localparam logic [15:0] LO_STEP = 16'(PULSE_LO_STEP);
   localparam logic [15:0] HI_STEP = 16'(PULSE_HI_STEP);
   localparam logic [7:0]  LAST    = 8'(PULSE_STEPS - 1);

   logic [15:0] pre_q;
   logic [7:0]  step_q;
   logic        step_end;

   assign step_end = (pre_q + 16'h0001) >= (freq_i ? HI_STEP : LO_STEP);

   always_ff @(posedge clock_i) begin
      if (rst_i || step_end) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         step_q <= 8'h00;
      end else if (step_end) begin
         step_q <= (step_q == LAST) ? 8'h00 : step_q + 8'h01;
      end
   end

   // Step never reaches 255, so full scale stays on and zero stays off
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         out_o <= 1'b0;
      end else begin
         out_o <= step_q < duty_i;
      end
   end

endmodule : pulse_gen

// file: test/hss_ctrl_props.sv
// Checker: port relations of the switch control block
`timescale 1ns/100ps
module hss_ctrl_props (
   input wire logic       clock_i,         // Clock
   input wire logic       rst_i,           // Reset
   input wire logic       soft_reset_i,    // Soft reset
   input wire logic       restart_clear_i, // Restart clear
   input wire logic       cyclic_sense_i,  // Cyclic sensing
   input wire logic [3:0] overcurrent_i,   // Overcurrent
   input wire logic [3:0] overtemp_i,      // Overtemperature
   input wire logic       fail_active_i,   // Fail state
   input wire logic [1:0] aux_pin_i,       // Aux levels
   input wire logic [3:0] switch_on_o,     // Switch drive
   input wire logic [1:0] aux_hs_on_o,     // Aux high-side
   input wire logic [1:0] aux_ls_on_o,     // Aux low-side
   input wire logic [1:0] aux_fail_o,      // Aux fail
   input wire logic [1:0] aux_wake_en_o,   // Aux wake enable
   input wire logic [1:0] aux_wake_o,      // Aux wake level
   input wire logic       second_timer_o   // Timer output
);
   // ==========================================================
   // Two sync flops; eight cycles bound every reaction but the wake filter
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_aux_excl; (aux_hs_on_o & aux_ls_on_o) == 2'b00; endproperty
   a_aux_excl: assert property (p_aux_excl) else $error("aux both sides on");
   property p_wake_excl; (aux_wake_en_o & (aux_hs_on_o | aux_ls_on_o | aux_fail_o)) == 2'b00;
   endproperty
   a_wake_excl: assert property (p_wake_excl) else $error("aux wake mixed");
   property p_wake_filt; $rose(aux_wake_o[0]) |-> aux_wake_en_o[0] && $past(aux_pin_i[0], 8)
      && $past(aux_pin_i[0], 300); endproperty
   a_wake_filt: assert property (p_wake_filt) else $error("wake unfiltered");
   property p_fail_idle; !fail_active_i [*8] |-> aux_fail_o == 2'b00; endproperty
   a_fail_idle: assert property (p_fail_idle) else $error("fail out idle");
   property p_oc_off; overcurrent_i[0] [*8] |-> !switch_on_o[0]; endproperty
   a_oc_off: assert property (p_oc_off) else $error("overcurrent drive");
   property p_ot_off; overtemp_i[3] [*8] |-> !switch_on_o[3]; endproperty
   a_ot_off: assert property (p_ot_off) else $error("overtemp drive");
   property p_soft; soft_reset_i [*8] |-> switch_on_o == 4'h0 && aux_hs_on_o == 2'b00
      && aux_ls_on_o == 2'b00 && aux_wake_en_o == 2'b00; endproperty
   a_soft: assert property (p_soft) else $error("soft reset values");
   property p_restart; restart_clear_i [*8] |-> switch_on_o == 4'h0; endproperty
   a_restart: assert property (p_restart) else $error("restart drive");
   property p_cyclic; (restart_clear_i && cyclic_sense_i) [*8] |-> !second_timer_o; endproperty
   a_cyclic: assert property (p_cyclic) else $error("restart timer");
endmodule : hss_ctrl_props

bind hss_ctrl hss_ctrl_props props (
   .clock_i, .rst_i, .soft_reset_i, .restart_clear_i, .cyclic_sense_i, .overcurrent_i,
   .overtemp_i, .fail_active_i, .aux_pin_i, .switch_on_o, .aux_hs_on_o, .aux_ls_on_o,
   .aux_fail_o, .aux_wake_en_o, .aux_wake_o, .second_timer_o);

// file: test/spi_host.sv
// Host model: link frames LSB first on a 12 ns clock
`timescale 1ns/100ps
module spi_host (
   output logic      sclk_o,      // Link clock, still between frames except while pulse() runs
   output logic      csn_n_o,     // Select, active low
   output logic      mosi_o,      // Data to device
   input  wire logic miso_i,      // Data from device
   input  wire logic miso_oe_n_i  // Device drives when low
);
   import hss_pkg::*;
   // ==========================================================
   // Released line reads inverted, never stale
   wire line = miso_oe_n_i ? ~mosi_o : miso_i;
   initial begin
      sclk_o = 1'b0;
      csn_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic pulse();
      repeat (3) begin
         #6 sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
      end
   endtask : pulse
   task automatic xfer(input frame_t f, output logic [7:0] rd);
      csn_n_o = 1'b0;
      for (int i = 0; i < 16; i++) begin
         mosi_o = f[i];
         #6 sclk_o = 1'b1;
         if (i > 7) rd[i-8] = line;
         #6 sclk_o = 1'b0;
      end
      #6 csn_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask : xfer
endmodule : spi_host

// file: test/testbench.sv
// Testbench: link-driven register and output checks
`timescale 1ns/100ps
module testbench;
   import hss_pkg::*;
   logic       clock_i, rst_i, soft_reset_i, sclk_i, csn_n_i, mosi_i, miso_o, miso_oe_n_o;
   logic       restart_clear_i, cyclic_sense_i, supply_ov_i, supply_uv_i, fail_active_i;
   logic       first_timer_i, pulse_one_freq_i, pulse_two_freq_i, second_timer_o;
   logic [3:0] overcurrent_i, overtemp_i, switch_on_o;
   logic [7:0] pulse_one_duty_i, pulse_two_duty_i, rv;
   logic [1:0] aux_pin_i, aux_hs_on_o, aux_ls_on_o, aux_fail_o, aux_wake_en_o, aux_wake_o;
   int         err_count, checks, hi, lo;
   hss_ctrl #(.TICK_CYC(4)) dut (.*);
   spi_host host (.sclk_o(sclk_i), .csn_n_o(csn_n_i), .mosi_o(mosi_i), .miso_i(miso_o),
      .miso_oe_n_i(miso_oe_n_o));
   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      host.xfer({d, 1'b1, a}, junk);
      cyc(10);
   endtask : wr
   // Reply lags one frame
   task automatic rd(input logic [6:0] a);
      host.xfer({8'h00, 1'b0, a}, rv);
      cyc(10);
      host.xfer({8'h00, 1'b0, a}, rv);
      cyc(10);
   endtask : rd
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (second_timer_o === lvl && n < 3000) begin
         cyc(1);
         n++;
      end
      if (n == 3000) begin
         err_count++;
         finish_test();
      end
   endtask : span
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [6:0] adr [6] = '{ADDR_SECOND_CYCLIC_TIMER, ADDR_SHUTDOWN, ADDR_SRC_A, ADDR_SRC_B, ADDR_AUX, 7'h11};
      logic [7:0] msk [6] = '{MASK_SECOND_CYCLIC_TIMER, MASK_SHUTDOWN, MASK_SRC, MASK_SRC, MASK_AUX, 8'h00};
      for (int i = 0; i < 6; i++) begin
         rd(adr[i]);
         check("reset value", rv, 0);
         wr(adr[i], 8'hff);
         rd(adr[i]);
         check("masked value", rv, msk[i]);
      end
      check("aux high", {aux_wake_en_o, aux_ls_on_o, aux_hs_on_o}, 6'h03);
      wr(ADDR_AUX, 8'hb6);
      check("aux low", {aux_wake_en_o, aux_ls_on_o, aux_hs_on_o}, 6'h0c);
      wr(ADDR_AUX, 8'h2c);
      check("aux wake", {aux_wake_en_o, aux_ls_on_o, aux_hs_on_o}, 6'h20);
      soft_reset_i = 1'b1;
      cyc(10);
      soft_reset_i = 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(adr[i]);
         check("soft reset", rv, 0);
      end
   endtask : t_regs
   task automatic t_switch();
      wr(ADDR_SRC_A, 8'h01);
      wr(ADDR_SRC_B, 8'h13);
      check("sources", switch_on_o, 4'h9);
      wr(ADDR_SECOND_CYCLIC_TIMER, 8'h60);
      check("timer high", {second_timer_o, switch_on_o}, 5'h1d);
      wr(ADDR_SECOND_CYCLIC_TIMER, 8'h30);
      span(1'b1, hi);
      span(1'b0, lo);
      span(1'b1, hi);
      span(1'b0, lo);
      check("on time", 16'(hi), 16'd40);
      check("period", 16'(hi + lo), 16'd400);
      wr(ADDR_SECOND_CYCLIC_TIMER, 8'h00);
      overcurrent_i = 4'h1;
      overtemp_i = 4'h8;
      cyc(10);
      {overcurrent_i, overtemp_i} = '0;
      rd(ADDR_SRC_A);
      check("oc clear", rv, 8'h00);
      rd(ADDR_SRC_B);
      check("ot clear", rv, 8'h03);
      wr(ADDR_SRC_A, 8'h04);
      pulse_one_duty_i = 8'hff;
      cyc(10);
      check("pulse full", switch_on_o, 4'h1);
      pulse_one_duty_i = 8'h00;
      cyc(10);
      check("pulse none", switch_on_o, 4'h0);
   endtask : t_switch
   task automatic t_supply();
      wr(ADDR_SRC_A, 8'h11);
      supply_ov_i = 1'b1;
      cyc(10);
      check("ov off", switch_on_o, 4'h0);
      supply_ov_i = 1'b0;
      rd(ADDR_SRC_A);
      check("no recovery", {rv, switch_on_o}, 12'h000);
      wr(ADDR_SRC_A, 8'h11);
      wr(ADDR_SHUTDOWN, 8'h10);
      supply_uv_i = 1'b1;
      cyc(10);
      check("uv off", switch_on_o, 4'h0);
      supply_uv_i = 1'b0;
      cyc(10);
      check("recovery", switch_on_o, 4'h3);
      wr(ADDR_SHUTDOWN, 8'h60);
      {supply_ov_i, supply_uv_i} = 2'b11;
      cyc(10);
      check("suppressed", switch_on_o, 4'h3);
      {supply_ov_i, supply_uv_i} = 2'b00;
   endtask : t_supply
   task automatic t_restart();
      wr(ADDR_SRC_B, 8'h03);
      wr(ADDR_SECOND_CYCLIC_TIMER, 8'h30);
      {restart_clear_i, cyclic_sense_i} = 2'b11;
      cyc(10);
      {restart_clear_i, cyclic_sense_i} = 2'b00;
      rd(ADDR_SECOND_CYCLIC_TIMER);
      check("timer cleared", rv, 8'h00);
      rd(ADDR_SRC_A);
      check("sources cleared", rv, 8'h00);
      wr(ADDR_AUX, 8'h05);
      aux_pin_i = 2'b01;
      cyc(200);
      check("wake early", aux_wake_o, 2'b00);
      cyc(200);
      check("wake late", aux_wake_o, 2'b01);
      wr(ADDR_AUX, 8'h28);
      fail_active_i = 1'b1;
      cyc(10);
      check("fail out", aux_fail_o, 2'b01);
   endtask : t_restart
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   initial begin
      {soft_reset_i, restart_clear_i, cyclic_sense_i, supply_ov_i, supply_uv_i} = '0;
      {fail_active_i, first_timer_i, pulse_one_freq_i, pulse_two_freq_i, aux_pin_i} = '0;
      {overcurrent_i, overtemp_i, pulse_one_duty_i, pulse_two_duty_i} = '0;
      rst_i = 1'b1;
      host.pulse();
      cyc(4);
      rst_i = 1'b0;
      host.pulse();
      cyc(2);
      t_regs();
      t_switch();
      t_supply();
      t_restart();
      finish_test();
   end
endmodule : testbench
